//--- common/hbp_pkg.sv
// Shared constants and types for the host bus request slave port
package hbp_pkg;

  // ****************************************
  // Widths and depths
  // ****************************************
  localparam int HBP_ADDR_W = 8;
  localparam int HBP_DATA_W = 32;
  localparam int HBP_FIFO_DEPTH = 2;
  localparam int HBP_SYNC_STAGES = 2;

  // ****************************************
  // Timing counts
  // ****************************************
  // Cycles of bus synchronisation after reset release before a grant may issue
  localparam int HBP_BUS_SYNC_CYCLES = 4;

  // ****************************************
  // Address map and reset values
  // ****************************************
  // Addresses below this limit hit I/O processor registers, the rest internal memory
  localparam logic [7:0] HBP_IOREG_LIMIT = 8'h80;
  localparam logic HBP_PIN_IDLE = 1'b1;
  localparam logic [31:0] HBP_DATA_RST = 32'h0000_0000;

  // ****************************************
  // Port states
  // ****************************************
  typedef enum logic [2:0] {
    HBP_ST_SYNC,
    HBP_ST_IDLE,
    HBP_ST_GRANT,
    HBP_ST_RD_WAIT,
    HBP_ST_RD_DONE,
    HBP_ST_WR_WAIT,
    HBP_ST_WR_DONE
  } hbp_state_t;

endpackage

//--- verilog/hbp_sync.sv
// Two-flop synchroniser for a vector of host pins
`timescale 1ns/10ps
module hbp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // No reset: the chain must keep sampling during reset so requests are seen
  always_ff @(posedge clk_sys_in) begin
    meta_reg <= async_in;
    sync_reg <= meta_reg;
  end

  assign sync_out = sync_reg;

endmodule

//--- verilog/hbp_host_port.sv
// Host bus request slave port: grant, ready handshake and I/O register access
`timescale 1ns/10ps
module hbp_host_port import hbp_pkg::*; #(
  parameter int ADDR_W = HBP_ADDR_W,
  parameter int DATA_W = HBP_DATA_W,
  parameter int FIFO_DEPTH = HBP_FIFO_DEPTH,
  parameter int SYNC_CYCLES = HBP_BUS_SYNC_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic ready_open_drain_in,
  input wire logic host_sel_n_in,
  input wire logic host_bus_req_n_in,
  input wire logic host_rd_n_in,
  input wire logic host_wr_n_in,
  input wire logic [ADDR_W-1:0] host_addr_in,
  input wire logic [DATA_W-1:0] host_data_in,
  output logic [DATA_W-1:0] host_data_out,
  output logic host_data_oe_n_out,
  output logic host_bus_grant_n_out,
  output logic host_wait_ready_out,
  output logic host_wait_ready_oe_n_out,
  output logic ioreg_wr_valid_out,
  input wire logic ioreg_wr_ready_in,
  output logic [ADDR_W-1:0] ioreg_wr_addr_out,
  output logic [DATA_W-1:0] ioreg_wr_data_out,
  output logic ioreg_rd_req_out,
  output logic [ADDR_W-1:0] ioreg_rd_addr_out,
  input wire logic ioreg_rd_valid_in,
  input wire logic [DATA_W-1:0] ioreg_rd_data_in
);

  localparam int PIN_W = 4 + ADDR_W + DATA_W;
  localparam int CNT_W = $clog2(SYNC_CYCLES + 1);
  localparam int FC_W = $clog2(FIFO_DEPTH + 1);
  localparam int ENT_W = ADDR_W + DATA_W;

  function automatic logic is_ioreg(input logic [ADDR_W-1:0] addr);
    is_ioreg = (addr < ADDR_W'(HBP_IOREG_LIMIT));
  endfunction

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [PIN_W-1:0] pins_s;
  logic sel_n_s, req_n_s, rd_n_s, wr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;

  hbp_sync #(.WIDTH(PIN_W)) u_sync (
    .clk_sys_in(clk_sys_in),
    .async_in({host_sel_n_in, host_bus_req_n_in, host_rd_n_in, host_wr_n_in, host_addr_in, host_data_in}),
    .sync_out(pins_s)
  );

  assign {sel_n_s, req_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pins_s;

  // ****************************************
  // State
  // ****************************************
  hbp_state_t state_reg, state_next;
  logic [CNT_W-1:0] sync_cnt_reg, sync_cnt_next;
  logic [CNT_W:0] rst_age_reg, rst_age_next;
  logic grant_n_reg, grant_n_next;
  // Strobe history one flop past the synchroniser: address and data settle before a fall is used
  logic [3:0] strb_hist_reg;
  logic rdy_low_reg, rdy_low_next;
  logic rdy_out_reg, rdy_out_next;
  logic rdy_oe_n_reg, rdy_oe_n_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic dout_oe_n_reg, dout_oe_n_next;
  logic rd_req_reg, rd_req_next;
  logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
  logic [ENT_W-1:0] fifo_reg [FIFO_DEPTH];
  logic [ENT_W-1:0] fifo_next [FIFO_DEPTH];
  logic [FC_W-1:0] fcnt_reg, fcnt_next;
  logic wr_valid_reg, wr_valid_next;
  logic both_act, rd_fall, wr_fall, fifo_room, pop, push;
  logic [FC_W-1:0] slot;

  assign both_act = ~sel_n_s & ~req_n_s;
  assign rd_fall = strb_hist_reg[3] & ~strb_hist_reg[1];
  assign wr_fall = strb_hist_reg[2] & ~strb_hist_reg[0];
  assign fifo_room = (fcnt_reg < FC_W'(FIFO_DEPTH));
  assign pop = wr_valid_reg & ioreg_wr_ready_in;

  // ****************************************
  // Grant and access sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    sync_cnt_next = sync_cnt_reg;
    grant_n_next = grant_n_reg;
    dout_next = dout_reg;
    dout_oe_n_next = dout_oe_n_reg;
    rd_req_next = 1'b0;
    rd_addr_next = rd_addr_reg;
    push = 1'b0;
    rst_age_next = rst_age_reg + (CNT_W+1)'(rst_age_reg <= (CNT_W+1)'(SYNC_CYCLES + 1));
    unique case (state_reg)
      HBP_ST_SYNC: begin
        // Grant withheld until bus sync completes; a held request is served after
        if (sync_cnt_reg == CNT_W'(SYNC_CYCLES)) begin
          state_next = HBP_ST_IDLE;
        end else begin
          sync_cnt_next = sync_cnt_reg + CNT_W'(1);
        end
      end
      HBP_ST_IDLE: begin
        // A request sampled at this edge is granted at this edge
        if (both_act) begin
          state_next = HBP_ST_GRANT;
          grant_n_next = 1'b0;
        end
      end
      HBP_ST_GRANT: begin
        if (!both_act) begin
          state_next = HBP_ST_IDLE;
          grant_n_next = HBP_PIN_IDLE;
        end else if (rd_fall) begin
          if (is_ioreg(addr_s)) begin
            rd_req_next = 1'b1;
            rd_addr_next = addr_s;
            state_next = HBP_ST_RD_WAIT;
          end else begin
            // Internal memory is not served: reads return zero
            dout_next = DATA_W'(HBP_DATA_RST);
            dout_oe_n_next = 1'b0;
            state_next = HBP_ST_RD_DONE;
          end
        end else if (wr_fall) begin
          if (!is_ioreg(addr_s)) begin
            state_next = HBP_ST_WR_DONE;
          end else if (fifo_room) begin
            push = 1'b1;
            state_next = HBP_ST_WR_DONE;
          end else begin
            state_next = HBP_ST_WR_WAIT;
          end
        end
      end
      HBP_ST_RD_WAIT: begin
        if (ioreg_rd_valid_in) begin
          dout_next = ioreg_rd_data_in;
          dout_oe_n_next = 1'b0;
          state_next = HBP_ST_RD_DONE;
        end
      end
      HBP_ST_RD_DONE: begin
        if (rd_n_s) begin
          dout_oe_n_next = HBP_PIN_IDLE;
          state_next = HBP_ST_GRANT;
        end
      end
      HBP_ST_WR_WAIT: begin
        if (fifo_room) begin
          push = 1'b1;
          state_next = HBP_ST_WR_DONE;
        end
      end
      HBP_ST_WR_DONE: begin
        if (wr_n_s) begin
          state_next = HBP_ST_GRANT;
        end
      end
    endcase
  end

  // ****************************************
  // Ready line
  // ****************************************
  always_comb begin
    // Low while waiting for grant, and while a read or a full-FIFO write is pending
    rdy_low_next = (state_next == HBP_ST_RD_WAIT) || (state_next == HBP_ST_WR_WAIT) ||
                   (((state_reg == HBP_ST_SYNC) || (state_reg == HBP_ST_IDLE)) && both_act);
    if (ready_open_drain_in) begin
      // Open drain: never driven high, only released
      rdy_out_next = 1'b0;
      rdy_oe_n_next = ~rdy_low_next;
    end else begin
      // Active drive: driven while select and request are low, else tristated
      rdy_out_next = ~rdy_low_next;
      rdy_oe_n_next = ~both_act;
    end
  end

  // ****************************************
  // Slave write FIFO
  // ****************************************
  always_comb begin
    slot = fcnt_reg - FC_W'(pop);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      fifo_next[i] = fifo_reg[i];
      if (pop && (i < FIFO_DEPTH - 1)) begin
        fifo_next[i] = fifo_reg[i+1];
      end
      if (push && (FC_W'(i) == slot)) begin
        fifo_next[i] = {addr_s, data_s};
      end
    end
    fcnt_next = fcnt_reg + FC_W'(push) - FC_W'(pop);
    wr_valid_next = (fcnt_next != '0);
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_reg <= HBP_ST_SYNC;
      sync_cnt_reg <= '0;
      grant_n_reg <= HBP_PIN_IDLE;
      strb_hist_reg <= {4{HBP_PIN_IDLE}};
      rst_age_reg <= '0;
      rdy_low_reg <= 1'b0;
      rdy_out_reg <= 1'b0;
      rdy_oe_n_reg <= HBP_PIN_IDLE;
      dout_reg <= DATA_W'(HBP_DATA_RST);
      dout_oe_n_reg <= HBP_PIN_IDLE;
      rd_req_reg <= 1'b0;
      rd_addr_reg <= '0;
      fcnt_reg <= '0;
      wr_valid_reg <= 1'b0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_reg[i] <= '0;
      end
    end else begin
      state_reg <= state_next;
      sync_cnt_reg <= sync_cnt_next;
      grant_n_reg <= grant_n_next;
      strb_hist_reg <= {strb_hist_reg[1:0], rd_n_s, wr_n_s};
      rst_age_reg <= rst_age_next;
      rdy_low_reg <= rdy_low_next;
      rdy_out_reg <= rdy_out_next;
      rdy_oe_n_reg <= rdy_oe_n_next;
      dout_reg <= dout_next;
      dout_oe_n_reg <= dout_oe_n_next;
      rd_req_reg <= rd_req_next;
      rd_addr_reg <= rd_addr_next;
      fcnt_reg <= fcnt_next;
      wr_valid_reg <= wr_valid_next;
      fifo_reg <= fifo_next;
    end
  end

  assign host_bus_grant_n_out = grant_n_reg;
  assign host_wait_ready_out = rdy_out_reg;
  assign host_wait_ready_oe_n_out = rdy_oe_n_reg;
  assign host_data_out = dout_reg;
  assign host_data_oe_n_out = dout_oe_n_reg;
  assign ioreg_rd_req_out = rd_req_reg;
  assign ioreg_rd_addr_out = rd_addr_reg;
  assign ioreg_wr_valid_out = wr_valid_reg;
  assign {ioreg_wr_addr_out, ioreg_wr_data_out} = fifo_reg[0];

  // ****************************************
  // Assertions
  // ****************************************
  AST_GRANT_HELD_AFTER_RESET: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rst_age_reg <= (CNT_W+1)'(SYNC_CYCLES + 1) |-> host_bus_grant_n_out)
    else $error("grant issued before bus sync finished");
  AST_INTMEM_READ_IGNORED: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_reg == HBP_ST_GRANT && both_act && rd_fall && !is_ioreg(addr_s)
    |=> !ioreg_rd_req_out && host_data_out == '0 && !host_data_oe_n_out)
    else $error("internal memory read reached register side");
  AST_WR_NO_STALL_WITH_ROOM: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_reg == HBP_ST_GRANT && both_act && !rd_fall && wr_fall && fifo_room |=> !rdy_low_reg)
    else $error("write stalled with free FIFO entry");
  AST_WR_STALL_WHEN_FULL: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_reg == HBP_ST_GRANT && both_act && !rd_fall && wr_fall && is_ioreg(addr_s) && !fifo_room
    |=> rdy_low_reg)
    else $error("full FIFO write not stalled");
  AST_OD_NEVER_HIGH: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $past(ready_open_drain_in) && !host_wait_ready_oe_n_out |-> !host_wait_ready_out)
    else $error("open-drain ready driven high");
  AST_AD_TRISTATE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !ready_open_drain_in && !both_act |=> host_wait_ready_oe_n_out)
    else $error("active-drive ready not released");
  AST_READY_AFTER_GRANT: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    $fell(host_bus_grant_n_out) |-> rdy_low_reg ##1 !rdy_low_reg)
    else $error("ready released before grant");
  AST_REQ_SAME_EDGE: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    state_reg == HBP_ST_IDLE && both_act |=> !host_bus_grant_n_out)
    else $error("sampled request not granted at once");
  CV_GRANT: cover property (@(posedge clk_sys_in) $fell(host_bus_grant_n_out));
  CV_READ: cover property (@(posedge clk_sys_in) state_reg == HBP_ST_RD_WAIT && ioreg_rd_valid_in);
  CV_WR_STALL: cover property (@(posedge clk_sys_in) state_reg == HBP_ST_WR_WAIT && fifo_room);
  CV_INTMEM: cover property (@(posedge clk_sys_in) state_reg == HBP_ST_GRANT && wr_fall && !is_ioreg(addr_s));

endmodule

//--- testbench/hbp_host_model.sv
// Host processor model driving select, request and strobes of the host port
`timescale 1ns/10ps
module hbp_host_model import hbp_pkg::*; (
  input wire logic clk_sys_in,
  input wire logic bus_grant_n_in,
  input wire logic ready_in,
  input wire logic data_oe_n_in,
  input wire logic [HBP_DATA_W-1:0] data_in,
  output logic sel_n_out = 1'b1,
  output logic bus_req_n_out = 1'b1,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic [HBP_ADDR_W-1:0] addr_out = 8'h00,
  output logic [HBP_DATA_W-1:0] data_out = 32'h0000_0000
);
  // Select and request move together and wait for the grant
  task automatic request(input logic on, output bit ok);
    int n;
    @(posedge clk_sys_in);
    sel_n_out <= ~on;
    bus_req_n_out <= ~on;
    ok = 1'b1;
    for (n = 0; on && n < 50; n++) begin
      @(posedge clk_sys_in);
      ok = (bus_grant_n_in === 1'b0);
      if (ok) break;
    end
  endtask

  // One strobe, held until ready is seen released; released lines then flip
  task automatic access(input bit wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
    int n;
    @(posedge clk_sys_in);
    addr_out <= a;
    data_out <= d;
    if (wr) wr_n_out <= 1'b0; else rd_n_out <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    ok = 1'b0;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge clk_sys_in);
      ok = (ready_in === 1'b1);
    end
    q = data_oe_n_in ? 32'hxxxx_xxxx : data_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    addr_out <= ~a;
    data_out <= ~d;
    repeat (2) @(posedge clk_sys_in);
  endtask
endmodule

//--- testbench/hbp_host_port_tb.sv
// Self-checking testbench for the host bus request slave port
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module hbp_host_port_tb import hbp_pkg::*; ;
  localparam int SYNC = 1;
  int bad_count = 0;
  int check_count = 0;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic od_mode = 1'b1;
  logic wr_ready = 1'b0;
  logic rd_valid = 1'b0;
  logic [31:0] rd_data = 32'h0000_0000;
  logic sel_n, req_n, rd_n, wr_n, data_oe_n, grant_n, rdy, rdy_oe_n, wr_valid, rd_req;
  logic [7:0] addr, wr_addr, rd_addr;
  logic [31:0] hdata, qdata, wr_data;
  logic [39:0] popped[$];
  wire rdy_pin = rdy_oe_n ? 1'b1 : rdy;
  bit ok;

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  hbp_host_port #(.SYNC_CYCLES(SYNC)) DUT (
    .clk_sys_in(clk_sys), .sys_rst_in(rst), .ready_open_drain_in(od_mode),
    .host_sel_n_in(sel_n), .host_bus_req_n_in(req_n), .host_rd_n_in(rd_n), .host_wr_n_in(wr_n),
    .host_addr_in(addr), .host_data_in(hdata), .host_data_out(qdata), .host_data_oe_n_out(data_oe_n),
    .host_bus_grant_n_out(grant_n), .host_wait_ready_out(rdy), .host_wait_ready_oe_n_out(rdy_oe_n),
    .ioreg_wr_valid_out(wr_valid), .ioreg_wr_ready_in(wr_ready), .ioreg_wr_addr_out(wr_addr),
    .ioreg_wr_data_out(wr_data), .ioreg_rd_req_out(rd_req), .ioreg_rd_addr_out(rd_addr),
    .ioreg_rd_valid_in(rd_valid), .ioreg_rd_data_in(rd_data));

  hbp_host_model host (
    .clk_sys_in(clk_sys), .bus_grant_n_in(grant_n), .ready_in(rdy_pin), .data_oe_n_in(data_oe_n),
    .data_in(qdata), .sel_n_out(sel_n), .bus_req_n_out(req_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .addr_out(addr), .data_out(hdata));

  // Register side: reads answered one edge later, accepted writes logged
  always @(posedge clk_sys) begin
    rd_valid <= rd_req;
    rd_data <= 32'hC0DE_0000 | {24'h00_0000, rd_addr};
    if (wr_valid && wr_ready) popped.push_back({wr_addr, wr_data});
  end

  task automatic sc_reset_grant(input logic mode);
    int n;
    rst <= 1'b1;
    od_mode <= mode;
    fork
      host.request(1'b1, ok);
      begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (n = 0; grant_n !== 1'b0 && n < 50; n++) @(posedge clk_sys);
        `CHK(n >= SYNC + 1, 1'b1)
        if (!mode) `CHK(rdy_pin, 1'b0)
      end
    join
    `CHK(ok, 1'b1)
    repeat (2) @(posedge clk_sys);
    `CHK({rdy, rdy_oe_n}, mode ? 2'b01 : 2'b10)
  endtask

  task automatic sc_read(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    host.access(1'b0, a, 32'h0000_0000, q, ok);
    `CHK({ok, q}, {1'b1, exp})
  endtask

  task automatic sc_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.access(1'b1, a, d, q, ok);
    `CHK(ok, 1'b1)
  endtask

  task automatic sc_write_stall();
    logic [31:0] q;
    wr_ready <= 1'b0;
    sc_write(8'h90, 32'hDEAD_BEEF);
    sc_write(8'h01, 32'h1111_0001);
    sc_write(8'h7F, 32'h2222_007F);
    `CHK(rdy_pin, 1'b1)
    fork
      host.access(1'b1, 8'h02, 32'h3333_0002, q, ok);
      begin
        repeat (8) @(posedge clk_sys);
        `CHK(rdy_pin, 1'b0)
        wr_ready <= 1'b1;
      end
    join
    `CHK(ok, 1'b1)
    repeat (4) @(posedge clk_sys);
    `CHK(popped.size(), 3)
    `CHK(popped[0], {8'h01, 32'h1111_0001})
    `CHK(popped[1], {8'h7F, 32'h2222_007F})
    `CHK(popped[2], {8'h02, 32'h3333_0002})
  endtask

  task automatic sc_release();
    host.request(1'b0, ok);
    repeat (4) @(posedge clk_sys);
    `CHK({grant_n, rdy_oe_n}, 2'b11)
  endtask

  task automatic final_report();
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    sc_reset_grant(1'b1);
    sc_read(8'h10, 32'hC0DE_0010);
    sc_read(8'h7F, 32'hC0DE_007F);
    sc_read(8'h80, 32'h0000_0000);
    sc_write_stall();
    sc_release();
    sc_reset_grant(1'b0);
    sc_read(8'h20, 32'hC0DE_0020);
    sc_release();
    final_report();
  end
endmodule
